// ==== pkg/burst_seq_consts.svh ====
// Purpose: Constants for the burst address sequencer.
// Assumes: Word addresses count 16-bit words.
// Notes: Included by the package and the design.
`ifndef BURST_SEQ_CONSTS_SVH
`define BURST_SEQ_CONSTS_SVH
`define ADDR_W 32
`define BL_128 2'h0
`define BL_64 2'h1
`define BL_16 2'h2
`define BL_32 2'h3
`define BL_DEFAULT 2'h3
`define WORDS_128 32'h40
`define WORDS_64 32'h20
`define WORDS_16 32'h8
`define WORDS_32 32'h10
`define HYBRID_BIT 2
`define BL_LSB 0
`define CMD_BURST_BIT 45
`define CMD_W 48
`define FIFO_DEPTH 8
`endif

// ==== pkg/burst_seq_pkg.sv ====
// Purpose: Types for the burst address sequencer.
// Assumes: Nothing beyond the constants header.
// Notes: Holds the sequencer state enum.
`include "burst_seq_consts.svh"
package burst_seq_pkg;
   typedef enum logic [1:0] {
      st_idle,
      st_wrap,
      st_linear
   } seq_state_e;
endpackage

// ==== rtl/burst_seq_fifo.sv ====
// Purpose: Source slot of the address FIFO of the burst sequencer.
// Assumes: The FIFO module is compiled from the sequencer's own file.
// Notes: Holds no module, so listing it never defines the FIFO twice.

// ==== rtl/burst_address_sequencer.sv ====
// Purpose: Produces the word-address order of one memory burst.
// Assumes: Inputs synchronous to core_clk; a burst lives while chip_sel_n is low.
// Notes: The address FIFO module is defined after the sequencer.
// Function
// - Legacy wrapped bursts stay inside one aligned group of the configured length.
// - Wrap groups of 16, 32, 64 and 128 bytes, length equals alignment.
// - Wrap starts at command word, runs to group end, wraps before start.
// - Hybrid burst does exactly one full wrap before leaving the group.
// - After that wrap, hybrid continues linearly until chip select rises.
// - Linear phase starts at the first word of the next aligned group.
// - Hybrid-enable bit two low gives hybrid order for wrapped bursts.
// - Hybrid-enable bit two high gives legacy wrapping order.
// - Addresses count 16-bit words; 16 bytes span eight words.
// - 128-byte hybrid wraps 64 words then continues past that group.
// - 64-byte hybrid wraps 32 words then continues into next group.
// - Command bit 45 high selects linear burst, low selects wrapped.
// - Length field 00=128, 01=64, 10=16, 11=32 bytes, 11 by default.
`timescale 1ns/10ps
`include "burst_seq_consts.svh"
module burst_address_sequencer
   import burst_seq_pkg::*;
#(
   parameter int ADDR_W = `ADDR_W,
   parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic chip_sel_n,
   input wire logic start,
   input wire logic [`CMD_W-1:0] command_address_word,
   input wire logic [15:0] config_word_zero,
   output logic addr_valid,
   input wire logic addr_ready,
   output logic [ADDR_W-1:0] addr_out,
   output logic burst_active
);
   // ----------------------------------------
   // Group size decode
   // ----------------------------------------
   // Word count of a wrap group from the length field.
   function automatic logic [ADDR_W-1:0] group_words(input logic [1:0] bl);
      case (bl)
         `BL_128: group_words = ADDR_W'(`WORDS_128);
         `BL_64: group_words = ADDR_W'(`WORDS_64);
         `BL_16: group_words = ADDR_W'(`WORDS_16);
         default: group_words = ADDR_W'(`WORDS_32);
      endcase
   endfunction

   // ----------------------------------------
   // Address arithmetic
   // ----------------------------------------
   // Next word in plain linear order.
   function automatic logic [ADDR_W-1:0] next_word(input logic [ADDR_W-1:0] a);
      next_word = a + 1'b1;
   endfunction

   // Next word inside the aligned group; the carry out of the group is dropped.
   function automatic logic [ADDR_W-1:0] wrap_step(input logic [ADDR_W-1:0] a,
      input logic [ADDR_W-1:0] m);
      wrap_step = (a & ~m) | (next_word(a) & m);
   endfunction

   // ----------------------------------------
   // Sequencer state
   // ----------------------------------------
   seq_state_e state_r, state_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [ADDR_W-1:0] start_r, start_nxt;
   logic [ADDR_W-1:0] mask_r, mask_nxt;
   logic hybrid_r, hybrid_nxt;
   logic [ADDR_W-1:0] step;
   logic [ADDR_W-1:0] cmd_word;
   logic push_ok;
   logic gen_valid;

   // The address field sits below the three command bits.
   assign cmd_word = ADDR_W'(command_address_word[`CMD_BURST_BIT-1:0]);
   assign gen_valid = state_r != st_idle && !chip_sel_n;

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      addr_nxt = addr_r;
      start_nxt = start_r;
      mask_nxt = mask_r;
      hybrid_nxt = hybrid_r;
      step = wrap_step(addr_r, mask_r);
      if (chip_sel_n) begin
         state_nxt = st_idle;
      end else begin
         case (state_r)
            st_idle: begin
               if (start) begin
                  addr_nxt = cmd_word;
                  start_nxt = cmd_word;
                  mask_nxt = group_words(config_word_zero[`BL_LSB +: 2]) - 1'b1;
                  // Hybrid order when the enable bit reads zero.
                  hybrid_nxt = !config_word_zero[`HYBRID_BIT];
                  if (command_address_word[`CMD_BURST_BIT]) begin
                     state_nxt = st_linear;
                  end else begin
                     state_nxt = st_wrap;
                  end
               end
            end
            st_wrap: begin
               if (push_ok) begin
                  if (hybrid_r && step == start_r) begin
                     // One full wrap done; jump to the next aligned group.
                     addr_nxt = next_word(start_r | mask_r);
                     state_nxt = st_linear;
                  end else begin
                     addr_nxt = step;
                  end
               end
            end
            st_linear: begin
               if (push_ok) addr_nxt = next_word(addr_r);
            end
            default: state_nxt = st_idle;
         endcase
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_r <= st_idle;
         addr_r <= '0;
         start_r <= '0;
         mask_r <= ADDR_W'(`WORDS_32) - 1'b1;
         hybrid_r <= 1'b0;
      end else if (clk_en) begin
         state_r <= state_nxt;
         addr_r <= addr_nxt;
         start_r <= start_nxt;
         mask_r <= mask_nxt;
         hybrid_r <= hybrid_nxt;
      end
   end

   assign burst_active = state_r != st_idle;

   // ----------------------------------------
   // Output buffer
   // ----------------------------------------
   // Chip select high flushes queued addresses, since the burst they belong to has ended.
   burst_seq_fifo #(
      .WIDTH(ADDR_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .reset(reset),
      .clk_en(clk_en),
      .flush(chip_sel_n),
      .in_valid(gen_valid),
      .in_ready(push_ok),
      .in_data(addr_r),
      .out_valid(addr_valid),
      .out_ready(addr_ready),
      .out_data(addr_out)
   );
endmodule // burst_address_sequencer

// ----------------------------------------
// Address FIFO
// ----------------------------------------
module burst_seq_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   // Pointers carry one extra bit so that full and empty differ without a count.
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic push, pop;

   assign in_ready = (wr_r - rd_r) != (AW+1)'(DEPTH);
   assign out_valid = wr_r != rd_r;
   assign out_data = mem[rd_r[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      wr_nxt = wr_r;
      rd_nxt = rd_r;
      if (flush) begin
         wr_nxt = '0;
         rd_nxt = '0;
      end else begin
         if (push) wr_nxt = wr_r + 1'b1;
         if (pop) rd_nxt = rd_r + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         wr_r <= '0;
         rd_r <= '0;
      end else if (clk_en) begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (clk_en && push && !flush) mem[wr_r[AW-1:0]] <= in_data;
   end
endmodule // burst_seq_fifo

// ==== testbench/burst_seq_sva.sv ====
// Purpose: Port checker for the burst address sequencer.
// Assumes: One clock, synchronous active-high reset.
// Notes: Predicts the first word and the hybrid jump from the command, other words from the last popped word.
`timescale 1ns/10ps
module burst_seq_sva #(parameter int ADDR_W = 32) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic chip_sel_n,
   input wire logic start,
   input wire logic [47:0] command_address_word,
   input wire logic [15:0] config_word_zero,
   input wire logic addr_valid,
   input wire logic addr_ready,
   input wire logic [ADDR_W-1:0] addr_out,
   input wire logic burst_active
);
   logic [ADDR_W-1:0] cmd_r, last_r, m;
   logic [2:0] cf_r;
   logic lin_r;
   logic [15:0] n_r;
   wire tk = clk_en && !chip_sel_n && start && !burst_active;
   wire pop = clk_en && !chip_sel_n && addr_valid && addr_ready;
   wire hyb = !lin_r && !cf_r[2];
   wire wr = !lin_r && (cf_r[2] || ADDR_W'(n_r) <= m);
   assign m = ADDR_W'(cf_r[1] ? {cf_r[0], 3'h7} : {~cf_r[0], 5'h1f});
   always_ff @(posedge core_clk) begin
      if (tk) begin
         cmd_r <= command_address_word[ADDR_W-1:0];
         cf_r <= config_word_zero[2:0];
         lin_r <= command_address_word[45];
      end
      n_r <= tk ? 16'h0 : n_r + 16'(pop);
      if (pop) begin
         last_r <= addr_out;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   property p_act; tk |=> burst_active; endproperty
   a_act: assert property (p_act) else $error("start not taken");
   property p_end; clk_en && chip_sel_n |=> !burst_active && !addr_valid; endproperty
   a_end: assert property (p_end) else $error("burst not ended");
   property p_first; tk ##1 clk_en && !chip_sel_n |=> addr_valid && addr_out == cmd_r; endproperty
   a_first: assert property (p_first) else $error("bad first word");
   property p_lin; pop && lin_r && n_r != 16'h0 |-> addr_out == last_r + 1'b1; endproperty
   a_lin: assert property (p_lin) else $error("bad linear step");
   property p_grp; pop && wr |-> (addr_out & ~m) == (cmd_r & ~m); endproperty
   a_grp: assert property (p_grp) else $error("left wrap group");
   property p_step; pop && wr && n_r != 16'h0 |-> addr_out == ((last_r & ~m) | ((last_r + 1'b1) & m));
   endproperty
   a_step: assert property (p_step) else $error("bad wrap step");
   property p_jump; pop && hyb && ADDR_W'(n_r) == m + 1'b1 |-> addr_out == (cmd_r | m) + 1'b1;
   endproperty
   a_jump: assert property (p_jump) else $error("bad hybrid jump");
   property p_hlin; pop && hyb && ADDR_W'(n_r) > m + 1'b1 |-> addr_out == last_r + 1'b1; endproperty
   a_hlin: assert property (p_hlin) else $error("bad hybrid linear");
endmodule // burst_seq_sva
bind burst_address_sequencer burst_seq_sva #(.ADDR_W(ADDR_W)) u_sva (.core_clk, .reset, .clk_en,
   .chip_sel_n, .start, .command_address_word, .config_word_zero, .addr_valid, .addr_ready,
   .addr_out, .burst_active);

// ==== testbench/addr_sink.sv ====
// Purpose: Consumer of sequenced word addresses.
// Assumes: Stall controls come from the bench.
// Notes: Slow mode takes a word every other cycle.
`timescale 1ns/10ps
module addr_sink (
   input wire logic core_clk,
   input wire logic hold,
   input wire logic slow,
   output logic addr_ready
);
   logic ph_r = 1'b0;
   always @(posedge core_clk) ph_r <= !ph_r;
   assign addr_ready = !hold && (!slow || ph_r);
endmodule // addr_sink

// ==== testbench/burst_address_sequencer_test.sv ====
// Purpose: Random bursts of every order with stalls.
// Assumes: clk_en is gated at random during odd bursts.
// Notes: Each burst except the one reset at k == 12 reads past one full group.
`timescale 1ns/10ps
module burst_address_sequencer_test;
   logic core_clk = 1'b0, reset = 1'b1, chip_sel_n = 1'b1, start = 1'b0, hold = 1'b0, slow = 1'b0;
   logic [47:0] cmd = 48'h0;
   logic gate = 1'b0, en_rnd = 1'b1, stop = 1'b0;
   logic clk_en;
   logic [15:0] cfg = 16'h0;
   logic addr_valid, addr_ready, burst_active;
   logic [31:0] addr_out;
   int error_cnt = 0, checks_done = 0, idx = 0, want = 0;
   always #5 core_clk = ~core_clk;
   assign clk_en = !gate || en_rnd;
   always @(posedge core_clk) #1 en_rnd = ($urandom & 32'h3) != 32'h0;
   burst_address_sequencer u_dut (.core_clk, .reset, .clk_en, .chip_sel_n, .start,
      .command_address_word(cmd), .config_word_zero(cfg), .addr_valid, .addr_ready, .addr_out,
      .burst_active);
   addr_sink u_sink (.core_clk, .hold, .slow, .addr_ready);
   function automatic logic [31:0] expect_addr(logic [47:0] c, logic [2:0] f, int i);
      logic [31:0] m;
      m = f[1] ? {28'h0, f[0], 3'h7} : {26'h0, ~f[0], 5'h1f};
      if (c[45] || (!f[2] && 32'(i) > m)) return (c[45] ? c[31:0] : c[31:0] & ~m) + 32'(i);
      return (c[31:0] & ~m) | ((c[31:0] + 32'(i)) & m);
   endfunction
   task automatic give_verdict();
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge core_clk) begin
      if (clk_en && !chip_sel_n && idx < want && (addr_valid && addr_ready) === 1'b1) begin
         checks_done++;
         if (addr_out !== expect_addr(cmd, cfg[2:0], idx)) begin
            error_cnt++;
            $display("MISMATCH %0t %h %h", $time, addr_out, expect_addr(cmd, cfg[2:0], idx));
         end
         idx++;
      end
   end
   initial begin
      void'($urandom(32'hbc185c31));
      repeat (3) @(posedge core_clk);
      #1 reset = 1'b0;
      for (int k = 0; k < 20 && !stop; k++) begin
         @(posedge core_clk);
         #1 cmd = 48'({$urandom, $urandom});
         cmd[45] = k >= 16;
         if (k[3]) cmd[5:0] = 6'h3f;
         cfg = 16'($urandom);
         cfg[2:0] = 3'(k);
         {hold, slow} = 2'(k);
         {idx, want} = {32'd0, 32'd140};
         {chip_sel_n, start} = 2'b01;
         @(posedge core_clk);
         #1 start = 1'b0;
         gate = k[0];
         repeat (12) @(posedge core_clk);
         #1 hold = 1'b0;
         if (k == 12) begin
            // A reset inside a burst must leave the sequencer idle with nothing queued.
            reset = 1'b1;
            repeat (2) @(posedge core_clk);
            #1 reset = 1'b0;
            want = idx;
            @(posedge core_clk);
            #1 checks_done++;
            if ({burst_active, addr_valid} !== 2'b00) begin
               error_cnt++;
               $display("MISMATCH %0t %h %h", $time, {burst_active, addr_valid}, 2'b00);
            end
         end
         for (int t = 0; t < 2000 && idx < want; t++) @(posedge core_clk);
         if (idx < want) begin
            error_cnt++;
            $display("MISMATCH %0t %h %h", $time, idx, want);
            stop = 1'b1;
         end
         #1 chip_sel_n = 1'b1;
         gate = 1'b0;
      end
      give_verdict();
   end
endmodule // burst_address_sequencer_test
